// >>> src/pmr_pkg.sv
// Constants for the port-one management status register view.
// Assumes one system clock and a plain 16-bit register port.

package pmr_pkg;

	// ==================================================
	// Bus shape
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;

	// ==================================================
	// Register offsets
	localparam logic [7:0] OFF_BASIC_STATUS = 8'h02;
	localparam logic [7:0] OFF_IDENT_LOW    = 8'h04;
	localparam logic [7:0] OFF_IDENT_HIGH   = 8'h06;
	localparam logic [7:0] OFF_ADVERTISE    = 8'h08;
	localparam logic [7:0] OFF_PARTNER      = 8'h0A;
	localparam logic [7:0] OFF_AN_CTRL      = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STATUS   = 8'h0E;
	localparam logic [7:0] OFF_IRQ_MASK     = 8'h10;

	// ==================================================
	// Basic status field positions
	localparam int unsigned BS_T4      = 15;
	localparam int unsigned BS_100F    = 14;
	localparam int unsigned BS_100H    = 13;
	localparam int unsigned BS_10F     = 12;
	localparam int unsigned BS_10H     = 11;
	localparam int unsigned BS_AN_DONE = 5;
	localparam int unsigned BS_AN_ABLE = 3;
	localparam int unsigned BS_LINK    = 2;

	// ==================================================
	// Ability fields: mirrored bit i sits at ABIL_POS[i]
	localparam int unsigned ABIL_N = 5;
	localparam int unsigned ABIL_POS [0:4] = '{5, 6, 7, 8, 10};
	localparam logic [4:0]  SELECTOR_VAL  = 5'h01;

	// ==================================================
	// Own control and event fields
	localparam int unsigned AN_EN_BIT = 0;
	localparam int unsigned EV_LINK    = 0;
	localparam int unsigned EV_AN_DONE = 1;
	localparam int unsigned EV_PARTNER = 2;
	localparam int unsigned EV_W       = 3;

	// ==================================================
	// Reset values
	localparam logic [4:0]  ADV_RESET      = 5'h1F;
	localparam logic        AN_EN_RESET    = 1'b1;
	localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;
	localparam logic [15:0] DATA_ZERO      = 16'h0000;

endpackage

// >>> src/pmr_port1_regs.sv
// Port-one management status register view with event interrupt.
// Assumes the mirrored bank drives link, completion and partner state
// synchronously to ref_clk_in.
//
// Chosen here: strobed register access.

`timescale 1ns/1ps
`default_nettype none

module pmr_port1_regs
	import pmr_pkg::*;
#(
	// Arbitrary neutral identifier values
	parameter logic [15:0] IDENT_LOW  = 16'h5A3C,
	parameter logic [15:0] IDENT_HIGH = 16'h00C7
) (
	input  wire logic              ref_clk_in,
	input  wire logic              rst_in,
	input  wire logic [ADDR_W-1:0] reg_addr_in,
	input  wire logic [DATA_W-1:0] reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output var  logic [DATA_W-1:0] reg_rdata_out,
	input  wire logic              an_complete_in,
	input  wire logic              link_up_in,
	input  wire logic [ABIL_N-1:0] partner_ability_in,
	input  wire logic              mirror_ctrl_wr_in,
	input  wire logic [ABIL_N-1:0] mirror_ctrl_wdata_in,
	output var  logic [ABIL_N-1:0] advertise_ctrl_out,
	output var  logic [ABIL_N-1:0] advertise_active_out,
	output var  logic              an_enable_out,
	output var  logic              irq_out
);

	// ==================================================
	// Declarations
	logic [ABIL_N-1:0] adv_q;
	logic [ABIL_N-1:0] adv_d;
	logic              an_en_q;
	logic              link_q;
	logic              an_done_q;
	logic [ABIL_N-1:0] partner_q;
	logic [ABIL_N-1:0] partner_d;
	logic [EV_W-1:0]   irq_status_q;
	logic [EV_W-1:0]   irq_status_d;
	logic [EV_W-1:0]   irq_mask_q;
	logic [EV_W-1:0]   irq_mask_d;
	logic [EV_W-1:0]   event_set;
	logic [DATA_W-1:0] basic_word;
	logic [DATA_W-1:0] adv_word;
	logic [DATA_W-1:0] partner_word;
	logic [DATA_W-1:0] rd_word;
	logic [ABIL_N-1:0] adv_wr_bits;
	logic              wr_adv;
	logic              wr_an_ctrl;
	logic              wr_irq_status;
	logic              wr_irq_mask;

	assign wr_adv        = reg_wr_in && (reg_addr_in == OFF_ADVERTISE);
	assign wr_an_ctrl    = reg_wr_in && (reg_addr_in == OFF_AN_CTRL);
	assign wr_irq_status = reg_wr_in && (reg_addr_in == OFF_IRQ_STATUS);
	assign wr_irq_mask   = reg_wr_in && (reg_addr_in == OFF_IRQ_MASK);

	// ==================================================
	// Ability field mapping, one bit per mirrored position
	for (genvar i = 0; i < ABIL_N; i++) begin : g_abil
		assign adv_wr_bits[i] = reg_wdata_in[ABIL_POS[i]];
	end

	always_comb begin
		adv_word     = {11'h000, SELECTOR_VAL};
		partner_word = {11'h000, SELECTOR_VAL};
		for (int i = 0; i < ABIL_N; i++) begin
			adv_word[ABIL_POS[i]]     = adv_q[i];
			partner_word[ABIL_POS[i]] = partner_q[i];
		end
	end

	// ==================================================
	// Basic status word; only the listed bits are ever set
	always_comb begin
		basic_word             = DATA_ZERO;
		basic_word[BS_100F]    = 1'b1;
		basic_word[BS_100H]    = 1'b1;
		basic_word[BS_10F]     = 1'b1;
		basic_word[BS_10H]     = 1'b1;
		basic_word[BS_AN_DONE] = an_done_q;
		basic_word[BS_AN_ABLE] = 1'b1;
		basic_word[BS_LINK]    = link_q;
	end

	// ==================================================
	// Shared advertisement storage
	// Host write wins over a same-cycle mirrored-bank write
	always_comb begin
		adv_d = adv_q;
		if (wr_adv) begin
			adv_d = adv_wr_bits;
		end else if (mirror_ctrl_wr_in) begin
			adv_d = mirror_ctrl_wdata_in;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			adv_q <= ADV_RESET;
		end else begin
			adv_q <= adv_d;
		end
	end

	// ==================================================
	// Auto-negotiation enable
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			an_en_q <= AN_EN_RESET;
		end else if (wr_an_ctrl) begin
			an_en_q <= reg_wdata_in[AN_EN_BIT];
		end
	end

	// ==================================================
	// Mirrored state capture
	// Partner ability is meaningless without negotiation, so it is held clear
	assign partner_d = an_en_q ? partner_ability_in : '0;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			link_q    <= 1'b0;
			an_done_q <= 1'b0;
			partner_q <= '0;
		end else begin
			link_q    <= link_up_in;
			an_done_q <= an_complete_in;
			partner_q <= partner_d;
		end
	end

	// ==================================================
	// Events and interrupt
	assign event_set[EV_LINK]    = link_q != link_up_in;
	assign event_set[EV_AN_DONE] = an_complete_in && !an_done_q;
	assign event_set[EV_PARTNER] = partner_q != partner_d;

	// Set beats write-one-to-clear so no event is lost
	always_comb begin
		irq_status_d = irq_status_q;
		if (wr_irq_status) begin
			irq_status_d = irq_status_q & ~reg_wdata_in[EV_W-1:0];
		end
		irq_status_d = irq_status_d | event_set;
		irq_mask_d = wr_irq_mask ? reg_wdata_in[EV_W-1:0] : irq_mask_q;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_status_q <= '0;
			irq_mask_q   <= IRQ_MASK_RESET;
			irq_out      <= 1'b0;
		end else begin
			irq_status_q <= irq_status_d;
			irq_mask_q   <= irq_mask_d;
			irq_out      <= |(irq_status_d & irq_mask_d);
		end
	end

	// ==================================================
	// Read port; writes to read-only offsets fall through untouched
	always_comb begin
		unique case (reg_addr_in)
			OFF_BASIC_STATUS: rd_word = basic_word;
			OFF_IDENT_LOW:    rd_word = IDENT_LOW;
			OFF_IDENT_HIGH:   rd_word = IDENT_HIGH;
			OFF_ADVERTISE:    rd_word = adv_word;
			OFF_PARTNER:      rd_word = partner_word;
			OFF_AN_CTRL:      rd_word = {15'h0000, an_en_q};
			OFF_IRQ_STATUS:   rd_word = {13'h0000, irq_status_q};
			OFF_IRQ_MASK:     rd_word = {13'h0000, irq_mask_q};
			default:          rd_word = DATA_ZERO;
		endcase
	end

	// Data stands for exactly the cycle after the strobe
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= DATA_ZERO;
		end else begin
			reg_rdata_out <= reg_rd_in ? rd_word : DATA_ZERO;
		end
	end

	// ==================================================
	// Outputs toward the link logic and mirrored bank
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			advertise_ctrl_out   <= ADV_RESET;
			advertise_active_out <= ADV_RESET;
			an_enable_out        <= AN_EN_RESET;
		end else begin
			advertise_ctrl_out   <= adv_d;
			advertise_active_out <= an_en_q ? adv_d : '0;
			an_enable_out        <= an_en_q;
		end
	end

endmodule

`default_nettype wire

// >>> verif/pmr_mirror_model.sv
// Far-side model: mirrored bank fed by the link partner.
// Assumes the bench asks for a new state by a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module pmr_mirror_model (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       upd_in,
	input  wire logic [6:0] val_in,
	output var  logic       link_out,
	output var  logic       an_out,
	output var  logic [4:0] abil_out
);
	// Levels move just after an edge, never mid-cycle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			{link_out, an_out, abil_out} <= 7'h00;
		else if (upd_in)
			{link_out, an_out, abil_out} <= val_in;
	end
endmodule
`default_nettype wire

// >>> verif/pmr_port1_regs_chk.sv
// Port checks for the port-one register view.
// Assumes it is bound into pmr_port1_regs.
`timescale 1ns/1ps
`default_nettype none
module pmr_port1_regs_chk
	import pmr_pkg::*;
#(
	parameter logic [15:0] IDENT_LOW  = 16'h5A3C,
	parameter logic [15:0] IDENT_HIGH = 16'h00C7
) (
	input wire logic              ref_clk_in,
	input wire logic              rst_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic              reg_wr_in,
	input wire logic              reg_rd_in,
	input wire logic [DATA_W-1:0] reg_rdata_out,
	input wire logic              an_complete_in,
	input wire logic              link_up_in,
	input wire logic [ABIL_N-1:0] partner_ability_in,
	input wire logic              mirror_ctrl_wr_in,
	input wire logic [ABIL_N-1:0] mirror_ctrl_wdata_in,
	input wire logic [ABIL_N-1:0] advertise_ctrl_out,
	input wire logic [ABIL_N-1:0] advertise_active_out,
	input wire logic              an_enable_out,
	input wire logic              irq_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	// ==========
	// Read answers
	status_fixed_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == OFF_BASIC_STATUS
		|-> (reg_rdata_out & 16'hFFDB) == 16'h7808) else $error("status fixed bits");
	ident_low_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == OFF_IDENT_LOW
		|-> reg_rdata_out == IDENT_LOW) else $error("ident low word");
	partner_fixed_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == OFF_PARTNER
		|-> (reg_rdata_out & 16'hFA1F) == 16'h0001) else $error("partner fixed bits");
	// Partner bits take no part while disabled
	partner_off_a: assert property (!an_enable_out [*3] ##1 (!an_enable_out && reg_rd_in
		&& reg_addr_in == OFF_PARTNER) |=> (reg_rdata_out & 16'h05E0) == 16'h0000)
		else $error("partner shown while disabled");
	// ==========
	// Shared advertisement storage
	adv_write_a: assert property ($past(reg_wr_in) && $past(reg_addr_in) == OFF_ADVERTISE
		|-> advertise_ctrl_out == {$past(reg_wdata_in[10]), $past(reg_wdata_in[8:5])}) else $error("adv write");
	mirror_wr_a: assert property ($past(mirror_ctrl_wr_in) && !($past(reg_wr_in)
		&& $past(reg_addr_in) == OFF_ADVERTISE) |-> advertise_ctrl_out == $past(mirror_ctrl_wdata_in))
		else $error("mirror write");
	ro_write_a: assert property ($past(reg_wr_in) && $past(reg_addr_in) != OFF_ADVERTISE
		&& !$past(mirror_ctrl_wr_in) |-> $stable(advertise_ctrl_out)) else $error("storage moved");
	adv_active_a: assert property (advertise_active_out == (an_enable_out ? advertise_ctrl_out : 5'h00))
		else $error("active advertisement");
	// Only a clear or a mask write can drop the level
	irq_fall_a: assert property ($fell(irq_out) |-> $past(reg_wr_in)
		&& ($past(reg_addr_in) == OFF_IRQ_STATUS || $past(reg_addr_in) == OFF_IRQ_MASK)) else $error("irq fell alone");
endmodule
bind pmr_port1_regs pmr_port1_regs_chk #(.IDENT_LOW(IDENT_LOW), .IDENT_HIGH(IDENT_HIGH)) u_chk (.*);
`default_nettype wire

// >>> verif/pmr_port1_regs_test.sv
// Self-checking bench for the port-one register view.
// Assumes the mirrored bank model drives the mirror levels.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, s); end end
module pmr_port1_regs_test;
	import pmr_pkg::*;
	logic        ref_clk_in, rst_in, wr, rd, mwr, upd, irq, en_o, rd_d, lk_w, an_w, lk, an, en;
	logic [7:0]  addr, offs [10] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h12, 8'h20};
	logic [15:0] wd, rdat, d, q [$];
	logic [4:0]  mwd, ctrl, act, ab_w, adv, ab;
	logic [6:0]  val;
	logic [2:0]  sts, msk;
	int          err_total, checked, cyc;
	// Arbitrary identifier values
	pmr_port1_regs #(.IDENT_LOW(16'h2B6E), .IDENT_HIGH(16'h0119)) u_pmr_port1_regs (.ref_clk_in(ref_clk_in),
		.rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdat), .an_complete_in(an_w), .link_up_in(lk_w), .partner_ability_in(ab_w),
		.mirror_ctrl_wr_in(mwr), .mirror_ctrl_wdata_in(mwd), .advertise_ctrl_out(ctrl),
		.advertise_active_out(act), .an_enable_out(en_o), .irq_out(irq));
	pmr_mirror_model u_pmr_mirror_model (.clk_in(ref_clk_in), .rst_in(rst_in), .upd_in(upd), .val_in(val),
		.link_out(lk_w), .an_out(an_w), .abil_out(ab_w));
	function automatic logic [15:0] mdl(input logic [7:0] a);
		logic [4:0] p;
		p = en ? ab : 5'h00;
		case (a)
			8'h02: return {10'h1E0, an, 2'h1, lk, 2'h0};
			8'h04: return 16'h2B6E;
			8'h06: return 16'h0119;
			8'h08: return {5'h00, adv[4], 1'b0, adv[3:0], 5'h01};
			8'h0A: return {5'h00, p[4], 1'b0, p[3:0], 5'h01};
			8'h0C: return {15'h0000, en};
			8'h0E: return {13'h0000, sts};
			8'h10: return {13'h0000, msk};
			default: return 16'h0000;
		endcase
	endfunction
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] v);
		@(posedge ref_clk_in);
		{wr, rd, addr, wd} <= {w, !w, a, v};
		if (!w) q.push_back(mdl(a));
	endtask
	task automatic idle(input int n);
		@(posedge ref_clk_in);
		{wr, rd, mwr, upd} <= 4'h0;
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic chk_all;
		foreach (offs[i]) acc(1'b0, offs[i], 16'h0000);
		idle(1);
	endtask
	// Events are judged against the old mirror state
	task automatic far(input logic [6:0] v);
		@(posedge ref_clk_in);
		{wr, rd, upd, val} <= {2'b00, 1'b1, v};
		sts = sts | {v[4:0] != ab, v[5] & !an, v[6] != lk};
		{lk, an, ab} = v;
		idle(3);
	endtask
	task automatic complete_run;
		if (err_total == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = !ref_clk_in;
	end
	always @(posedge ref_clk_in) rd_d <= rd;
	always @(negedge ref_clk_in) if (rd_d) `CHK("rdata", q.pop_front(), rdat)
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc > 3000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		{wr, rd, mwr, upd, addr, wd, mwd, val, lk, an, ab, sts, msk} = '0;
		{adv, en, rst_in} = 7'h7F;
		void'($urandom(32'hE63A37D3));
		repeat (6) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		#1 `CHK("act", 5'h1F, act)
		chk_all();
		foreach (offs[i]) if (offs[i] < 8'h08 || offs[i] == 8'h0A || offs[i] > 8'h10) acc(1'b1, offs[i], 16'hFFFF);
		chk_all();
		repeat (4) begin
			d = 16'($urandom);
			acc(1'b1, 8'h08, d);
			adv = {d[10], d[8:5]};
			acc(1'b0, 8'h08, 16'h0000);
			idle(0);
			`CHK("ctrl", adv, ctrl)
		end
		// Host write wins over a same-cycle mirror write
		acc(1'b1, 8'h08, 16'h0120);
		{mwr, mwd} <= {1'b1, 5'h1E};
		adv = 5'h09;
		idle(0);
		`CHK("ctrl", adv, ctrl)
		@(posedge ref_clk_in);
		{mwr, mwd} <= {1'b1, 5'h1A};
		adv = 5'h1A;
		idle(0);
		`CHK("ctrl", adv, ctrl)
		acc(1'b1, 8'h10, 16'h0007);
		msk = 3'h7;
		for (int k = 0; k < 4; k++) begin
			far({k[0], k[1], 5'($urandom)});
			`CHK("irq", |(sts & msk), irq)
			chk_all();
			acc(1'b1, 8'h0E, {13'h0000, sts});
			sts = 3'h0;
			idle(1);
			`CHK("irq", 1'b0, irq)
		end
		acc(1'b1, 8'h10, 16'h0000);
		msk = 3'h0;
		far(7'h6A);
		`CHK("irq", 1'b0, irq)
		acc(1'b1, 8'h0C, 16'h0000);
		en = 1'b0;
		idle(3);
		`CHK("act", 5'h00, act)
		`CHK("en", en, en_o)
		acc(1'b0, 8'h0A, 16'h0000);
		acc(1'b0, 8'h0C, 16'h0000);
		acc(1'b1, 8'h0C, 16'h0001);
		en = 1'b1;
		idle(1);
		`CHK("act", adv, act)
		`CHK("en", en, en_o)
		complete_run();
	end
endmodule
`default_nettype wire
